// ### sat_timer.sv
`timescale 1ns/1ps
// Contract
// - split select zero: one 16-bit auto-reload timer
// - 16-bit wrap loads reload pair, sets high flag
// - 16-bit overflow interrupts while timer interrupts enabled
// - low-byte wrap interrupts when low enable set
// - split: two 8-bit counters, own reload bytes
// - split: run bit gates high counter only
// - 16-bit: run bit starts and stops timer
// - split byte clock: system_clock, else prescaled source
// - external select: system_clock/12 or external/8
// - external divided tick synchronised to system_clock
// - split: each byte wrap sets its flag
// - split: high wrap interrupts, low too if enabled
// - low flag sets on low wrap, any mode
// - flags cleared only by software writes
// - lfo falling edge captures count into reload while timer interrupts enabled
// - control bit layout as documented
// - control bit 1 reads zero, ignores writes
// - per-byte system_clock selects in clock control
// - 16-bit mode: low select clocks whole timer
module sat_timer (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// special-function register port
	input wire sat_pkg::sat_sfr_req_t sfr_req_in,
	output logic [7:0] sfr_rdata_out,
	// interrupt enable from the core and request back
	input wire logic timer_irq_enable_in,
	output logic timer_irq_out,
	// oscillator pins
	input wire logic ext_osc_in,
	input wire logic lfo_in
);

	// ********************************************************************
	// state
	// ********************************************************************
	sat_pkg::sat_state_t state_q; // all registered state
	sat_pkg::sat_state_t state_d; // next state

	// decoded writes
	logic wr_ctrl; // write to timer_control_status
	logic wr_clock_control_register; // write to clock_control_register
	logic wr_rl_lo; // write to reload_low_byte
	logic wr_rl_hi; // write to reload_high_byte
	logic wr_cnt_lo; // write to count_low_byte
	logic wr_cnt_hi; // write to count_high_byte

	// control fields
	logic split; // split_mode_select
	logic run; // run_control
	logic ext_sel; // external_clock_select
	logic cap_en; // lfo_capture_enable
	logic low_irq_en; // low_overflow_irq_enable

	// ticks
	logic div12_tick; // system clock divided by 12
	logic ext_tick; // external clock divided by 8, synchronised
	logic src_tick; // source picked by the external select
	logic tick_lo; // low byte (or whole timer) clock
	logic tick_hi; // high byte clock in split mode

	// counting events
	logic step_lo; // low byte advances
	logic step_hi; // high byte advances
	logic wrap_lo; // low byte steps from 0xff, to 0x00 or to its reload
	logic wrap_hi; // high byte (or 16-bit) wraps
	logic lfo_fall; // falling edge of the synchronised lfo
	logic capture; // capture event

	// ********************************************************************
	// decode and field aliases
	// ********************************************************************
	assign wr_ctrl = sfr_req_in.wr && (sfr_req_in.addr == sat_pkg::SAT_OFS_CONTROL);
	assign wr_clock_control_register = sfr_req_in.wr && (sfr_req_in.addr == sat_pkg::SAT_OFS_CLOCK_CONTROL);
	assign wr_rl_lo = sfr_req_in.wr && (sfr_req_in.addr == sat_pkg::SAT_OFS_RELOAD_LOW);
	assign wr_rl_hi = sfr_req_in.wr && (sfr_req_in.addr == sat_pkg::SAT_OFS_RELOAD_HIGH);
	assign wr_cnt_lo = sfr_req_in.wr && (sfr_req_in.addr == sat_pkg::SAT_OFS_COUNT_LOW);
	assign wr_cnt_hi = sfr_req_in.wr && (sfr_req_in.addr == sat_pkg::SAT_OFS_COUNT_HIGH);

	assign split = state_q.ctrl[sat_pkg::SAT_BIT_SPLIT];
	assign run = state_q.ctrl[sat_pkg::SAT_BIT_RUN];
	assign ext_sel = state_q.ctrl[sat_pkg::SAT_BIT_EXT_CLK];
	assign cap_en = state_q.ctrl[sat_pkg::SAT_BIT_CAPTURE_EN];
	assign low_irq_en = state_q.ctrl[sat_pkg::SAT_BIT_LOW_IRQ_EN];

	// ********************************************************************
	// tick generation
	// ********************************************************************
	// prescaler pulse once every twelve system clocks
	assign div12_tick = (state_q.div12 == sat_pkg::SAT_DIV12_LAST);
	// eighth rising edge seen after the two-flop synchroniser
	assign ext_tick = state_q.ext_sync[1] && !state_q.ext_sync[2] &&
		(state_q.ext_div == sat_pkg::SAT_EXT_LAST);
	// external select picks the prescaled source for both bytes
	assign src_tick = ext_sel ? ext_tick : div12_tick;
	// low select clocks the low byte, or the whole timer in 16-bit mode
	assign tick_lo = state_q.low_system_clock ? 1'b1 : src_tick;
	assign tick_hi = state_q.high_system_clock ? 1'b1 : src_tick;

	// ********************************************************************
	// counting events
	// ********************************************************************
	// split: low always runs, high gated by run; 16-bit: run gates all
	assign step_lo = split ? tick_lo : (run && tick_lo);
	assign step_hi = split ? (run && tick_hi) : (run && tick_lo && wrap_lo);
	assign wrap_lo = step_lo && (state_q.count_lo == 8'hff);
	assign wrap_hi = step_hi && (state_q.count_hi == 8'hff);
	assign lfo_fall = state_q.lfo_sync[2] && !state_q.lfo_sync[1];
	assign capture = lfo_fall && cap_en && timer_irq_enable_in;

	// ********************************************************************
	// next-state logic
	// ********************************************************************
	always_comb begin
		state_d = state_q;
		// synchronisers: first stage is read only by the second
		state_d.ext_sync = {state_q.ext_sync[1:0], ext_osc_in};
		state_d.lfo_sync = {state_q.lfo_sync[1:0], lfo_in};
		// system clock prescaler counts 0..11
		if (div12_tick) begin
			state_d.div12 = 4'h0;
		end else begin
			state_d.div12 = state_q.div12 + 4'h1;
		end
		// external prescaler counts synchronised rising edges
		if (state_q.ext_sync[1] && !state_q.ext_sync[2]) begin
			state_d.ext_div = state_q.ext_div + 3'h1;
		end
		// low byte: step by one, reload or clear to zero on wrap
		if (wrap_lo) begin
			// split reloads its own byte, 16-bit reloads only at full wrap
			if (split || wrap_hi) begin
				state_d.count_lo = state_q.reload_lo;
			end else begin
				state_d.count_lo = 8'h00;
			end
		end else if (step_lo) begin
			state_d.count_lo = state_q.count_lo + 8'h01;
		end
		// high byte: step by one, reload on wrap
		if (wrap_hi) begin
			state_d.count_hi = state_q.reload_hi;
		end else if (step_hi) begin
			state_d.count_hi = state_q.count_hi + 8'h01;
		end
		// software writes to counts win over ticks
		if (wr_cnt_lo) begin
			state_d.count_lo = sfr_req_in.wdata;
		end
		if (wr_cnt_hi) begin
			state_d.count_hi = sfr_req_in.wdata;
		end
		// reload registers: software write, then capture on top
		if (wr_rl_lo) begin
			state_d.reload_lo = sfr_req_in.wdata;
		end
		if (wr_rl_hi) begin
			state_d.reload_hi = sfr_req_in.wdata;
		end
		if (capture) begin
			state_d.reload_lo = state_q.count_lo;
			state_d.reload_hi = state_q.count_hi;
		end
		// clock control: only the two timer selects live here
		if (wr_clock_control_register) begin
			state_d.high_system_clock = sfr_req_in.wdata[sat_pkg::SAT_BIT_HIGH_SYSTEM_CLOCK];
			state_d.low_system_clock = sfr_req_in.wdata[sat_pkg::SAT_BIT_LOW_SYSTEM_CLOCK];
		end
		// control register write; bit 1 always held zero
		if (wr_ctrl) begin
			state_d.ctrl = sfr_req_in.wdata;
			state_d.ctrl[sat_pkg::SAT_BIT_UNUSED] = 1'b0;
		end
		// hardware sets win over a software clear in the same cycle
		if (wrap_hi || capture) begin
			state_d.ctrl[sat_pkg::SAT_BIT_HIGH_FLAG] = 1'b1;
		end
		if (wrap_lo) begin
			state_d.ctrl[sat_pkg::SAT_BIT_LOW_FLAG] = 1'b1;
		end
		// registered read data, one cycle after the strobe
		if (sfr_req_in.rd) begin
			case (sfr_req_in.addr)
				sat_pkg::SAT_OFS_CONTROL: begin
					state_d.rdata = state_q.ctrl;
				end
				sat_pkg::SAT_OFS_CLOCK_CONTROL: begin
					state_d.rdata = 8'h00;
					state_d.rdata[sat_pkg::SAT_BIT_HIGH_SYSTEM_CLOCK] = state_q.high_system_clock;
					state_d.rdata[sat_pkg::SAT_BIT_LOW_SYSTEM_CLOCK] = state_q.low_system_clock;
				end
				sat_pkg::SAT_OFS_RELOAD_LOW: begin
					state_d.rdata = state_q.reload_lo;
				end
				sat_pkg::SAT_OFS_RELOAD_HIGH: begin
					state_d.rdata = state_q.reload_hi;
				end
				sat_pkg::SAT_OFS_COUNT_LOW: begin
					state_d.rdata = state_q.count_lo;
				end
				sat_pkg::SAT_OFS_COUNT_HIGH: begin
					state_d.rdata = state_q.count_hi;
				end
				default: begin
					state_d.rdata = 8'h00; // unmapped offsets read zero
				end
			endcase
		end
	end

	// ********************************************************************
	// state register
	// ********************************************************************
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state_q <= '0;
			state_q.ctrl <= sat_pkg::SAT_RST_BYTE;
			state_q.reload_lo <= sat_pkg::SAT_RST_BYTE;
			state_q.reload_hi <= sat_pkg::SAT_RST_BYTE;
			state_q.count_lo <= sat_pkg::SAT_RST_BYTE;
			state_q.count_hi <= sat_pkg::SAT_RST_BYTE;
		end else begin
			state_q <= state_d;
		end
	end

	// ********************************************************************
	// outputs
	// ********************************************************************
	assign sfr_rdata_out = state_q.rdata;
	// with the timer enable set, high flag interrupts, low flag only with its enable
	assign timer_irq_out = timer_irq_enable_in &&
		(state_q.ctrl[sat_pkg::SAT_BIT_HIGH_FLAG] ||
		(state_q.ctrl[sat_pkg::SAT_BIT_LOW_FLAG] && low_irq_en));

	// ********************************************************************
	// assertions
	// ********************************************************************
	default clocking sat_cb @(posedge core_clk_in);
	endclocking
	default disable iff (reset_in);

	logic no_cnt_wr; // no software write to either count byte
	assign no_cnt_wr = !wr_cnt_lo && !wr_cnt_hi;

	// 16-bit wrap loads the reload pair and sets the high flag
	property p_wrap16;
		logic [15:0] rl;
		(!split && run && tick_lo && {state_q.count_hi, state_q.count_lo} == 16'hffff &&
			no_cnt_wr, rl = {state_q.reload_hi, state_q.reload_lo})
		|=> ({state_q.count_hi, state_q.count_lo} == rl) &&
			state_q.ctrl[sat_pkg::SAT_BIT_HIGH_FLAG];
	endproperty
	a_wrap16: assert property (p_wrap16) else $error("16-bit wrap did not reload");

	// 16-bit count steps by exactly one when not at a wrap
	property p_step16;
		(!split && run && tick_lo && state_q.count_lo != 8'hff && no_cnt_wr)
		|=> state_q.count_lo == $past(state_q.count_lo) + 8'h01 && $stable(state_q.count_hi);
	endproperty
	a_step16: assert property (p_step16) else $error("16-bit count did not step by one");

	// 16-bit low wrap below the full wrap clears the low byte and carries
	property p_carry16;
		(!split && wrap_lo && !wrap_hi && no_cnt_wr)
		|=> state_q.count_lo == 8'h00 && state_q.count_hi == $past(state_q.count_hi) + 8'h01;
	endproperty
	a_carry16: assert property (p_carry16) else $error("16-bit carry wrong");

	// 16-bit mode stopped holds the whole count
	property p_stop16;
		(!split && !run && no_cnt_wr) |=> $stable({state_q.count_hi, state_q.count_lo});
	endproperty
	a_stop16: assert property (p_stop16) else $error("stopped 16-bit timer moved");

	// split mode: low byte runs with run cleared, high byte holds
	property p_split_run;
		(split && !run && state_q.low_system_clock && no_cnt_wr && state_q.count_lo != 8'hff)
		|=> state_q.count_lo == $past(state_q.count_lo) + 8'h01 && $stable(state_q.count_hi);
	endproperty
	a_split_run: assert property (p_split_run) else $error("split run gating wrong");

	// split high wrap reloads its own byte and sets the high flag
	property p_split_hi;
		(split && run && tick_hi && state_q.count_hi == 8'hff && !wr_cnt_hi)
		|=> state_q.count_hi == $past(state_q.reload_hi) &&
			state_q.ctrl[sat_pkg::SAT_BIT_HIGH_FLAG];
	endproperty
	a_split_hi: assert property (p_split_hi) else $error("split high wrap wrong");

	// split low wrap reloads from its own reload byte
	property p_split_lo;
		(split && wrap_lo && !wr_cnt_lo) |=> state_q.count_lo == $past(state_q.reload_lo);
	endproperty
	a_split_lo: assert property (p_split_lo) else $error("split low wrap wrong");

	// low wrap sets the low flag in either mode
	property p_low_flag;
		wrap_lo |=> state_q.ctrl[sat_pkg::SAT_BIT_LOW_FLAG];
	endproperty
	a_low_flag: assert property (p_low_flag) else $error("low flag not set on wrap");

	// high flag never falls without a control write
	property p_flag_hold;
		(state_q.ctrl[sat_pkg::SAT_BIT_HIGH_FLAG] && !wr_ctrl)
		|=> state_q.ctrl[sat_pkg::SAT_BIT_HIGH_FLAG];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("high flag cleared by hardware");

	// bit 1 of the control register reads zero
	property p_bit1;
		(sfr_req_in.rd && sfr_req_in.addr == sat_pkg::SAT_OFS_CONTROL)
		|=> sfr_rdata_out[sat_pkg::SAT_BIT_UNUSED] == 1'b0;
	endproperty
	a_bit1: assert property (p_bit1) else $error("control bit 1 read non-zero");

	// capture copies the count into the reload pair
	property p_capture;
		logic [15:0] cnt;
		(capture, cnt = {state_q.count_hi, state_q.count_lo})
		|=> {state_q.reload_hi, state_q.reload_lo} == cnt && timer_irq_out;
	endproperty
	a_capture: assert property (p_capture) else $error("capture did not copy count");

	// prescaler pulses are twelve cycles apart
	property p_div12;
		div12_tick |=> !div12_tick [*8] ##1 !div12_tick ##1 !div12_tick ##1 !div12_tick
			##1 div12_tick;
	endproperty
	a_div12: assert property (p_div12) else $error("system_clock/12 spacing wrong");

	// interrupt output rises only with the timer interrupt enable set
	property p_irq;
		$rose(timer_irq_out) |-> timer_irq_enable_in &&
			(state_q.ctrl[sat_pkg::SAT_BIT_HIGH_FLAG] ||
			(state_q.ctrl[sat_pkg::SAT_BIT_LOW_FLAG] && low_irq_en));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt raised without cause");

	c_wrap16: cover property (!split && wrap_hi);
	c_split_lo: cover property (split && wrap_lo && !run);
	c_capture: cover property (capture);
	c_ext_tick: cover property (ext_sel && ext_tick);
	c_low_irq: cover property (low_irq_en && wrap_lo && timer_irq_enable_in);

endmodule

// ### sat_pkg.sv
package sat_pkg;

	// ********************************************************************
	// register offsets on the special-function register port
	// ********************************************************************
	localparam logic [7:0] SAT_OFS_CLOCK_CONTROL = 8'h8e; // clock_control_register
	localparam logic [7:0] SAT_OFS_CONTROL = 8'hc8; // timer_control_status
	localparam logic [7:0] SAT_OFS_RELOAD_LOW = 8'hca; // reload_low_byte
	localparam logic [7:0] SAT_OFS_RELOAD_HIGH = 8'hcb; // reload_high_byte
	localparam logic [7:0] SAT_OFS_COUNT_LOW = 8'hcc; // count_low_byte
	localparam logic [7:0] SAT_OFS_COUNT_HIGH = 8'hcd; // count_high_byte

	// ********************************************************************
	// timer_control_status field positions
	// ********************************************************************
	localparam int SAT_BIT_HIGH_FLAG = 7; // high_overflow_flag
	localparam int SAT_BIT_LOW_FLAG = 6; // low_overflow_flag
	localparam int SAT_BIT_LOW_IRQ_EN = 5; // low_overflow_irq_enable
	localparam int SAT_BIT_CAPTURE_EN = 4; // lfo_capture_enable
	localparam int SAT_BIT_SPLIT = 3; // split_mode_select
	localparam int SAT_BIT_RUN = 2; // run_control
	localparam int SAT_BIT_UNUSED = 1; // reads zero
	localparam int SAT_BIT_EXT_CLK = 0; // external_clock_select

	// ********************************************************************
	// clock_control_register field positions
	// ********************************************************************
	localparam int SAT_BIT_HIGH_SYSTEM_CLOCK = 5; // high_byte_system_clock_select
	localparam int SAT_BIT_LOW_SYSTEM_CLOCK = 4; // low_byte_system_clock_select

	// ********************************************************************
	// reset values and timing counts
	// ********************************************************************
	localparam logic [7:0] SAT_RST_BYTE = 8'h00; // every register resets to zero
	localparam int SAT_SYSTEM_CLOCK_DIV = 12; // system clock prescale
	localparam int SAT_EXT_DIV = 8; // external oscillator prescale
	localparam logic [3:0] SAT_DIV12_LAST = 4'(SAT_SYSTEM_CLOCK_DIV - 1);
	localparam logic [2:0] SAT_EXT_LAST = 3'(SAT_EXT_DIV - 1);

	// ********************************************************************
	// carriers
	// ********************************************************************
	typedef struct packed {
		logic [7:0] addr; // register offset
		logic wr; // write strobe, one cycle
		logic rd; // read strobe, one cycle
		logic [7:0] wdata; // write data
	} sat_sfr_req_t;

	typedef struct packed {
		logic [7:0] ctrl; // timer_control_status, bit 1 held zero
		logic high_system_clock; // high_byte_system_clock_select
		logic low_system_clock; // low_byte_system_clock_select
		logic [7:0] reload_lo; // reload_low_byte
		logic [7:0] reload_hi; // reload_high_byte
		logic [7:0] count_lo; // count_low_byte
		logic [7:0] count_hi; // count_high_byte
		logic [3:0] div12; // system clock prescaler
		logic [2:0] ext_sync; // external oscillator synchroniser and edge stage
		logic [2:0] ext_div; // external oscillator prescaler
		logic [2:0] lfo_sync; // low-frequency oscillator synchroniser and edge stage
		logic [7:0] rdata; // read data register
	} sat_state_t;

endpackage

// ### tb_split_autoreload_timer.sv
`timescale 1ns/1ps
module tb_split_autoreload_timer;

	// ****************************************************************
	// short names for register offsets
	// ****************************************************************
	localparam logic [7:0] CTL = sat_pkg::SAT_OFS_CONTROL;
	localparam logic [7:0] CKC = sat_pkg::SAT_OFS_CLOCK_CONTROL;
	localparam logic [7:0] RLL = sat_pkg::SAT_OFS_RELOAD_LOW;
	localparam logic [7:0] RLH = sat_pkg::SAT_OFS_RELOAD_HIGH;
	localparam logic [7:0] CNL = sat_pkg::SAT_OFS_COUNT_LOW;
	localparam logic [7:0] CNH = sat_pkg::SAT_OFS_COUNT_HIGH;

	// ****************************************************************
	// stimulus and observed signals
	// ****************************************************************
	logic core_clk_in = 1'b0; // system clock
	logic reset_in = 1'b1; // synchronous reset
	sat_pkg::sat_sfr_req_t req; // register port request
	logic [7:0] rdata; // register port read data
	logic irq_en; // core timer interrupt enable
	logic irq; // interrupt request
	logic ext_osc = 1'b0; // external oscillator
	logic lfo = 1'b1; // low-frequency oscillator
	logic ext_on = 1'b0; // external oscillator runs
	int err_count = 0; // mismatches
	int n_compared = 0; // comparisons
	int ext_edges = 0; // external rising edges seen
	int k; // random span
	logic [7:0] v; // scratch read value
	logic [7:0] s; // scratch start value
	logic [7:0] ofs[6] = '{CTL, CKC, RLL, RLH, CNL, CNH}; // mapped offsets

	// clocks: 50 MHz system, unrelated external oscillator
	always #10 core_clk_in = ~core_clk_in;
	always #37 if (ext_on) ext_osc = ~ext_osc;
	always @(posedge ext_osc) ext_edges++;

	sat_timer DUT (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.sfr_req_in(req),
		.sfr_rdata_out(rdata),
		.timer_irq_enable_in(irq_en),
		.timer_irq_out(irq),
		.ext_osc_in(ext_osc),
		.lfo_in(lfo)
	);

	// ****************************************************************
	// bus tasks and comparisons
	// ****************************************************************
	// one-cycle write strobe, launched on the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk_in);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge core_clk_in);
		req.wr = 1'b0;
	endtask

	// one-cycle read strobe; data is registered on the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk_in);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge core_clk_in);
		req.rd = 1'b0;
		d = rdata;
	endtask

	// compare a value against a window of legal values
	task automatic rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
		n_compared++;
		if (!(got >= lo && got <= hi) || $isunknown(got)) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask

	// exact compare
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// read a register and compare it
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		rd(a, v);
		chk(v, exp);
	endtask

	// wait a bounded time for the interrupt request to rise
	task automatic wait_irq();
		for (int i = 0; i < 200 && irq !== 1'b1; i++) @(negedge core_clk_in);
		chk({7'h00, irq}, 8'h01);
	endtask

	// prints counts and verdict, ends the run
	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// watchdog: the whole sequence needs far fewer cycles
	initial begin
		#200000;
		err_count++;
		results();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		req = '0;
		irq_en = 1'b0;
		k = $urandom(32'h70cd8b1f);
		repeat (12) @(posedge core_clk_in);
		@(negedge core_clk_in);
		reset_in = 1'b0;
		// reset values, unmapped read
		foreach (ofs[i]) rdc(ofs[i], 8'h00);
		rdc(8'hc9, 8'h00);
		chk({7'h00, irq}, 8'h00);
		// control layout, unused bit, clock selects, unmapped write
		wr(CTL, 8'h02);
		rdc(CTL, 8'h00);
		wr(CTL, 8'h3b);
		rdc(CTL, 8'h39);
		wr(CTL, 8'h00);
		wr(CKC, 8'hff);
		rdc(CKC, 8'h30);
		wr(8'hc9, 8'haa);
		rdc(8'hc9, 8'h00);
		// random write and readback of bytes
		for (int i = 0; i < 8; i++) begin
			s = 8'($urandom);
			wr(ofs[2 + i % 4], s);
			rdc(ofs[2 + i % 4], s);
		end
		// exact step count at system clock, 16-bit
		for (int i = 0; i < 4; i++) begin
			s = 8'($urandom_range(0, 192));
			k = $urandom_range(3, 30);
			wr(CNL, s);
			wr(CNH, 8'h00);
			wr(CTL, 8'h04);
			repeat (k) @(negedge core_clk_in);
			wr(CTL, 8'h00);
			rdc(CNL, 8'(s + k + 2));
			repeat (5) @(negedge core_clk_in);
			rdc(CNL, 8'(s + k + 2));
			rdc(CNH, 8'h00);
		end
		// 16-bit wrap with reload and interrupt
		wr(RLL, 8'h34);
		wr(RLH, 8'h12);
		wr(CNL, 8'hfd);
		wr(CNH, 8'hff);
		irq_en = 1'b1;
		wr(CTL, 8'h04);
		wait_irq();
		wr(CTL, 8'hc0);
		rdc(CTL, 8'hc0);
		rdc(CNH, 8'h12);
		rd(CNL, v);
		rng(v, 8'h34, 8'h3f);
		irq_en = 1'b0;
		@(negedge core_clk_in);
		chk({7'h00, irq}, 8'h00);
		repeat (10) @(negedge core_clk_in);
		rdc(CTL, 8'hc0);
		wr(CTL, 8'h00);
		rdc(CTL, 8'h00);
		// low-byte interrupt in 16-bit mode
		wr(CNL, 8'hfe);
		wr(CNH, 8'h00);
		irq_en = 1'b1;
		wr(CTL, 8'h24);
		wait_irq();
		wr(CTL, 8'h60);
		rdc(CTL, 8'h60);
		rdc(CNH, 8'h01);
		// split mode: low runs alone, high held by run bit
		wr(RLL, 8'hf0);
		wr(RLH, 8'h80);
		wr(CNL, 8'hfe);
		wr(CNH, 8'hfe);
		wr(CTL, 8'h08);
		repeat (10) @(negedge core_clk_in);
		rdc(CNH, 8'hfe);
		rdc(CTL, 8'h48);
		chk({7'h00, irq}, 8'h00);
		wr(CTL, 8'h28);
		wait_irq();
		rd(CNL, v);
		rng(v, 8'hf0, 8'hff);
		wr(CTL, 8'h0c);
		wait_irq();
		wr(CTL, 8'h88);
		rd(CTL, v);
		chk(v & 8'h80, 8'h80);
		rd(CNH, v);
		rng(v, 8'h80, 8'h8f);
		// split: high byte on divided clock, low on system clock
		wr(CKC, 8'h10);
		wr(CNH, 8'h00);
		wr(CTL, 8'h0c);
		repeat (118) @(negedge core_clk_in);
		wr(CTL, 8'h08);
		rd(CNH, v);
		rng(v, 8'h0a, 8'h0b);
		wr(CTL, 8'h00);
		// 16-bit on divide-by-12; high select must not matter
		for (int i = 0; i < 2; i++) begin
			wr(CKC, i ? 8'h20 : 8'h00);
			wr(CNL, 8'h00);
			k = $urandom_range(100, 300);
			wr(CTL, 8'h04);
			repeat (k) @(negedge core_clk_in);
			wr(CTL, 8'h00);
			rd(CNL, v);
			rng(v, 8'((k + 2) / 12), 8'((k + 2) / 12 + 1));
		end
		// external oscillator divided by 8
		wr(CKC, 8'h00);
		wr(CNL, 8'h00);
		ext_on = 1'b1;
		wr(CTL, 8'h05);
		ext_edges = 0;
		repeat (400) @(negedge core_clk_in);
		wr(CTL, 8'h01);
		k = ext_edges / 8;
		rd(CNL, v);
		rng(v, 8'(k - 1), 8'(k + 1));
		ext_on = 1'b0;
		// capture on falling edge of the slow oscillator
		for (int i = 0; i < 2; i++) begin
			irq_en = (i == 0);
			wr(CKC, 8'h10);
			wr(CTL, 8'h00);
			wr(RLL, 8'h00);
			wr(CNL, 8'h00);
			wr(CNH, 8'h00);
			wr(CTL, 8'h14);
			repeat (20) @(negedge core_clk_in);
			lfo = 1'b0;
			repeat (8) @(negedge core_clk_in);
			lfo = 1'b1;
			rd(CTL, v);
			chk(v & 8'h80, i == 0 ? 8'h80 : 8'h00);
			chk({7'h00, irq}, i == 0 ? 8'h01 : 8'h00);
			wr(CTL, 8'h00);
			rd(CNL, s);
			rd(RLL, v);
			if (i == 0) rng(v, s - 8'd14, s - 8'd4);
			else chk(v, 8'h00);
		end
		results();
	end

endmodule
